// file: brg_pkg.sv
package brg_pkg;

    // register byte addresses on the bus
    localparam logic [7:0] RATE_CONTROL_ADDR   = 8'h00;
    localparam logic [7:0] RECV_CTRL_STAT_ADDR = 8'h04;
    localparam logic [7:0] DIVISOR_LOW_ADDR    = 8'h08;
    localparam logic [7:0] DIVISOR_HIGH_ADDR   = 8'h0c;
    localparam logic [7:0] XMIT_CTRL_STAT_ADDR = 8'h10;
    localparam logic [7:0] RATE_STATUS_ADDR    = 8'h14;

    // field positions
    localparam int RECV_IDLE_BIT   = 6;
    localparam int WIDE_SEL_BIT    = 3;
    localparam int CLK_SRC_BIT     = 7;
    localparam int MODE_SYNC_BIT   = 4;
    localparam int HIGH_SPEED_BIT  = 2;

    // writable masks: other bits belong to blocks outside this one
    localparam logic [7:0] RATE_CONTROL_WMASK = 8'h1b;
    localparam logic [7:0] RECV_CTRL_WMASK    = 8'hf8;
    localparam logic [7:0] XMIT_CTRL_WMASK    = 8'hfd;

    // reset values
    localparam logic [7:0] RATE_CONTROL_RST   = 8'h00;
    localparam logic [7:0] RECV_CTRL_RST      = 8'h00;
    localparam logic [7:0] XMIT_CTRL_RST      = 8'h00;
    localparam logic [7:0] DIVISOR_RST        = 8'h00;
    localparam logic [7:0] XMIT_EMPTY_RST     = 8'h02;

    // prescale terminal counts per mode; each divides by one more
    localparam logic [5:0] PRESCALE_SLOW      = 6'h3f;
    localparam logic [5:0] PRESCALE_MID       = 6'h0f;
    localparam logic [5:0] PRESCALE_FAST      = 6'h03;

    // axi responses
    localparam logic [1:0] RESP_OKAY          = 2'h0;
    localparam logic [1:0] RESP_SLVERR        = 2'h2;

endpackage : brg_pkg

// file: brg_rate_timer.sv
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps

module brg_rate_timer (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        receiver_idle_flag,
    output logic             bit_tick,
    output logic             serial_clock_tick,
    output logic             sync_mode,
    output logic             wide_counter_select,
    output logic             high_speed_select
);

    typedef struct packed {
        logic [7:0]  aw_addr;
        logic        aw_full;
        logic [31:0] w_data;
        logic        w_strb0;
        logic        w_full;
        logic        b_valid;
        logic [1:0]  b_resp;
        logic        r_valid;
        logic [1:0]  r_resp;
        logic [31:0] r_data;
        logic [7:0]  rate_control;
        logic [7:0]  recv_ctrl;
        logic [7:0]  xmit_ctrl;
        logic [7:0]  divisor_low;
        logic [7:0]  divisor_high;
        logic [5:0]  prescale;
        logic [15:0] count;
        logic        tick;
        logic        sclk_tick;
        logic        idle_meta;
        logic        idle_sync;
    } brg_state_t;

    brg_state_t state_reg;
    brg_state_t state_next;

    // true when the address names a mapped register
    function automatic logic brg_mapped(input logic [7:0] a);
        brg_mapped = (a == brg_pkg::RATE_CONTROL_ADDR) || (a == brg_pkg::RECV_CTRL_STAT_ADDR)
            || (a == brg_pkg::DIVISOR_LOW_ADDR) || (a == brg_pkg::DIVISOR_HIGH_ADDR)
            || (a == brg_pkg::XMIT_CTRL_STAT_ADDR) || (a == brg_pkg::RATE_STATUS_ADDR);
    endfunction : brg_mapped

    logic        wide_sel;
    logic        speed_sel;
    logic        mode_sync;
    logic [5:0]  prescale_top;
    logic [15:0] divisor_n;
    logic        do_write;
    logic        divisor_write;
    logic [7:0]  wbyte;
    logic [7:0]  rd_byte;

    // mode decode and period selection
    always_comb
    begin
        wide_sel  = state_reg.rate_control[brg_pkg::WIDE_SEL_BIT];
        speed_sel = state_reg.xmit_ctrl[brg_pkg::HIGH_SPEED_BIT];
        mode_sync = state_reg.xmit_ctrl[brg_pkg::MODE_SYNC_BIT];
        // 8-bit width counts the low byte only
        divisor_n = wide_sel ? {state_reg.divisor_high, state_reg.divisor_low}
                             : {8'h00, state_reg.divisor_low};
        if (mode_sync)
        begin
            prescale_top = brg_pkg::PRESCALE_FAST;
        end
        else if (!wide_sel && !speed_sel)
        begin
            prescale_top = brg_pkg::PRESCALE_SLOW;
        end
        else if (wide_sel && speed_sel)
        begin
            prescale_top = brg_pkg::PRESCALE_FAST;
        end
        else
        begin
            prescale_top = brg_pkg::PRESCALE_MID;
        end
    end

    // register read mux
    always_comb
    begin
        unique case (s_axi_araddr)
            brg_pkg::RATE_CONTROL_ADDR:
                rd_byte = state_reg.rate_control
                    | ({7'h00, state_reg.idle_sync} << brg_pkg::RECV_IDLE_BIT);
            brg_pkg::RECV_CTRL_STAT_ADDR: rd_byte = state_reg.recv_ctrl;
            brg_pkg::DIVISOR_LOW_ADDR:    rd_byte = state_reg.divisor_low;
            brg_pkg::DIVISOR_HIGH_ADDR:   rd_byte = state_reg.divisor_high;
            brg_pkg::XMIT_CTRL_STAT_ADDR: rd_byte = state_reg.xmit_ctrl | brg_pkg::XMIT_EMPTY_RST;
            brg_pkg::RATE_STATUS_ADDR:    rd_byte = state_reg.count[7:0];
            default:                      rd_byte = 8'h00;
        endcase
    end

    // bus, registers and the timer itself
    always_comb
    begin
        state_next           = state_reg;
        state_next.tick      = 1'b0;
        state_next.sclk_tick = 1'b0;
        state_next.idle_meta = receiver_idle_flag;
        state_next.idle_sync = state_reg.idle_meta;
        do_write      = state_reg.aw_full && state_reg.w_full && !state_reg.b_valid;
        wbyte         = state_reg.w_data[7:0];
        divisor_write = 1'b0;

        if (s_axi_awvalid && s_axi_awready)
        begin
            state_next.aw_addr = s_axi_awaddr;
            state_next.aw_full = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            state_next.w_data  = s_axi_wdata;
            state_next.w_strb0 = s_axi_wstrb[0];
            state_next.w_full  = 1'b1;
        end

        // commit once both halves are held
        if (do_write)
        begin
            state_next.aw_full = 1'b0;
            state_next.w_full  = 1'b0;
            state_next.b_valid = 1'b1;
            state_next.b_resp  = brg_mapped(state_reg.aw_addr) ? brg_pkg::RESP_OKAY
                                                              : brg_pkg::RESP_SLVERR;
            if (state_reg.w_strb0)
            begin
                unique case (state_reg.aw_addr)
                    brg_pkg::RATE_CONTROL_ADDR:
                        state_next.rate_control = wbyte & brg_pkg::RATE_CONTROL_WMASK;
                    brg_pkg::RECV_CTRL_STAT_ADDR:
                        state_next.recv_ctrl = wbyte & brg_pkg::RECV_CTRL_WMASK;
                    brg_pkg::XMIT_CTRL_STAT_ADDR:
                        state_next.xmit_ctrl = wbyte & brg_pkg::XMIT_CTRL_WMASK;
                    brg_pkg::DIVISOR_LOW_ADDR:
                    begin
                        state_next.divisor_low = wbyte;
                        divisor_write = 1'b1;
                    end
                    brg_pkg::DIVISOR_HIGH_ADDR:
                    begin
                        state_next.divisor_high = wbyte;
                        divisor_write = 1'b1;
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
        if (state_reg.b_valid && s_axi_bready)
        begin
            state_next.b_valid = 1'b0;
        end

        // reads answer one cycle after the address is taken
        if (s_axi_arvalid && s_axi_arready)
        begin
            state_next.r_valid = 1'b1;
            state_next.r_data  = {24'h000000, rd_byte};
            state_next.r_resp  = brg_mapped(s_axi_araddr) ? brg_pkg::RESP_OKAY
                                                          : brg_pkg::RESP_SLVERR;
        end
        else if (state_reg.r_valid && s_axi_rready)
        begin
            state_next.r_valid = 1'b0;
        end

        // prescaler then divisor counter; a tick every (top+1)*(n+1) cycles
        if (divisor_write)
        begin
            state_next.prescale = 6'h00;
            state_next.count    = 16'h0000;
        end
        else if (state_reg.prescale >= prescale_top)
        begin
            state_next.prescale = 6'h00;
            if (state_reg.count >= divisor_n)
            begin
                state_next.count     = 16'h0000;
                state_next.tick      = 1'b1;
                state_next.sclk_tick = mode_sync
                    && state_reg.xmit_ctrl[brg_pkg::CLK_SRC_BIT];
            end
            else
            begin
                state_next.count = state_reg.count + 16'h0001;
            end
        end
        else
        begin
            state_next.prescale = state_reg.prescale + 6'h01;
        end
    end

    // single state register; idle flag resets high as the receiver does
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg              <= '0;
            state_reg.rate_control <= brg_pkg::RATE_CONTROL_RST;
            state_reg.recv_ctrl    <= brg_pkg::RECV_CTRL_RST;
            state_reg.xmit_ctrl    <= brg_pkg::XMIT_CTRL_RST;
            state_reg.divisor_low  <= brg_pkg::DIVISOR_RST;
            state_reg.divisor_high <= brg_pkg::DIVISOR_RST;
            state_reg.idle_meta    <= 1'b1;
            state_reg.idle_sync    <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // handshakes: one write and one read outstanding at a time
    assign s_axi_awready       = !state_reg.aw_full && !state_reg.b_valid;
    assign s_axi_wready        = !state_reg.w_full && !state_reg.b_valid;
    assign s_axi_arready       = !state_reg.r_valid;
    assign s_axi_bvalid        = state_reg.b_valid;
    assign s_axi_bresp         = state_reg.b_resp;
    assign s_axi_rvalid        = state_reg.r_valid;
    assign s_axi_rdata         = state_reg.r_data;
    assign s_axi_rresp         = state_reg.r_resp;
    assign bit_tick            = state_reg.tick;
    assign serial_clock_tick   = state_reg.sclk_tick;
    assign sync_mode           = state_reg.xmit_ctrl[brg_pkg::MODE_SYNC_BIT];
    assign wide_counter_select = state_reg.rate_control[brg_pkg::WIDE_SEL_BIT];
    assign high_speed_select   = state_reg.xmit_ctrl[brg_pkg::HIGH_SPEED_BIT];

endmodule : brg_rate_timer

// file: brg_rate_timer_asserts.sv
`timescale 1ns/10ps

// port-level checks; sees only what the rate timer drives and takes
module brg_rate_timer_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        bit_tick,
    input wire logic        serial_clock_tick,
    input wire logic        sync_mode,
    input wire logic        wide_counter_select,
    input wire logic        high_speed_select
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // reset check must not be switched off by reset itself
    property p_rst; disable iff (1'b0) !aresetn |=> !bit_tick && !s_axi_bvalid
        && !s_axi_rvalid && !sync_mode && !wide_counter_select && !high_speed_select; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    // shortest period is 4 cycles, so no tick may follow within three
    property p_gap; bit_tick |=> !bit_tick [*3]; endproperty
    a_gap: assert property (p_gap) else $error("bit ticks closer than four cycles");
    property p_sclk; serial_clock_tick |-> bit_tick && sync_mode; endproperty
    a_sclk: assert property (p_sclk) else $error("serial clock outside sync mode");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_bans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid; endproperty
    a_bans: assert property (p_bans) else $error("write answer late");
    property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_busy: assert property (p_busy) else $error("new write taken before response");
    property p_rup; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
    a_rup: assert property (p_rup) else $error("read data upper bits set");
endmodule : brg_rate_timer_asserts

bind brg_rate_timer brg_rate_timer_asserts chk_u (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .bit_tick,
    .serial_clock_tick, .sync_mode, .wide_counter_select, .high_speed_select);

// file: tb_brg_rate_timer.sv
`timescale 1ns/10ps

module tb_brg_rate_timer;
    logic        aclk = 1'b0, aresetn = 1'b0, receiver_idle_flag = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        bit_tick, serial_clock_tick, sync_mode, wide_counter_select, high_speed_select;
    logic        s, w, h, c;
    logic [15:0] n;
    int          err_count = 0, num_checks = 0, cnt, e;
    logic [7:0]  addrs [5] = '{brg_pkg::RATE_CONTROL_ADDR, brg_pkg::RECV_CTRL_STAT_ADDR,
        brg_pkg::DIVISOR_LOW_ADDR, brg_pkg::DIVISOR_HIGH_ADDR, brg_pkg::XMIT_CTRL_STAT_ADDR};
    logic [7:0]  rst_v [5] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h02};
    logic [7:0]  all_v [5] = '{brg_pkg::RATE_CONTROL_WMASK, brg_pkg::RECV_CTRL_WMASK, 8'hff,
        8'hff, brg_pkg::XMIT_CTRL_WMASK | 8'h02};

    brg_rate_timer dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .receiver_idle_flag, .bit_tick,
        .serial_clock_tick, .sync_mode, .wide_counter_select, .high_speed_select);

    // free-running 100 MHz clock
    always #5 aclk = ~aclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // bready stays high, so each channel is released only at its own handshake
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] rsp);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [7:0] ev, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        check(s_axi_rdata, {24'h0, ev});
        check({30'h0, s_axi_rresp}, {30'h0, er});
    endtask : rchk

    // counts edges up to the next sampled tick
    task automatic wait_tick(output int k);
        k = 0;
        do
        begin
            @(posedge aclk);
            k++;
        end while (bit_tick !== 1'b1);
    endtask : wait_tick

    function automatic int exp_period(logic sy, logic wd, logic hs, logic [15:0] dv);
        int p;
        p = sy ? 4 : (wd ? (hs ? 4 : 16) : (hs ? 16 : 64));
        return p * ((wd ? int'(dv) : int'(dv[7:0])) + 1);
    endfunction : exp_period

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    // watchdog well beyond the longest expected run
    initial
    begin
        #900000;
        err_count++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(44));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 5; i++) rchk(addrs[i], rst_v[i], brg_pkg::RESP_OKAY);
        rchk(8'h18, 8'h00, brg_pkg::RESP_SLVERR);
        wr(8'h18, 8'h55, r);
        check({30'h0, r}, {30'h0, brg_pkg::RESP_SLVERR});
        receiver_idle_flag <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            wr(addrs[i], 8'hff, r);
            rchk(addrs[i], all_v[i], brg_pkg::RESP_OKAY);
        end
        $display("test registers done");
        // every mode combination; high byte random to show it is ignored in 8-bit width
        for (int i = 0; i < 8; i++)
        begin
            {s, w, h} = 3'(i);
            c = 1'($urandom_range(1));
            n = {8'($urandom_range(1)), 8'($urandom_range(7))};
            wr(brg_pkg::XMIT_CTRL_STAT_ADDR, {c, 2'b00, s, 1'b0, h, 2'b00}, r);
            wr(brg_pkg::RATE_CONTROL_ADDR, {4'h0, w, 3'h0}, r);
            wr(brg_pkg::DIVISOR_HIGH_ADDR, n[15:8], r);
            wr(brg_pkg::DIVISOR_LOW_ADDR, n[7:0], r);
            wait_tick(cnt);
            wait_tick(cnt);
            check(32'(cnt), 32'(exp_period(s, w, h, n)));
            check({28'h0, serial_clock_tick, sync_mode, wide_counter_select, high_speed_select},
                {28'h0, s & c, s, w, h});
        end
        $display("test rate modes done");
        // long period, then a short divisor mid-count: old count must not linger
        wr(brg_pkg::XMIT_CTRL_STAT_ADDR, 8'h00, r);
        wr(brg_pkg::RATE_CONTROL_ADDR, 8'h00, r);
        wr(brg_pkg::DIVISOR_LOW_ADDR, 8'hff, r);
        wait_tick(cnt);
        repeat (50) @(posedge aclk);
        wr(brg_pkg::DIVISOR_LOW_ADDR, 8'h02, r);
        wait_tick(cnt);
        e = exp_period(1'b0, 1'b0, 1'b0, 16'h0002);
        check(32'(cnt), 32'(e));
        $display("test divisor restart done");
        // read answer held while rready is low, taken only once rready returns
        s_axi_rready <= 1'b0;
        s_axi_araddr <= brg_pkg::DIVISOR_LOW_ADDR;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
        end while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        repeat (3) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
        end while (s_axi_rvalid !== 1'b1);
        check(s_axi_rdata, 32'h00000002);
        $display("test read hold done");
        report_and_stop();
    end
endmodule : tb_brg_rate_timer
